/* shared/plc_pkg.sv */
// Register map, reset values and timing constants of the parallel line controller
package plc_pkg;
  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] PLC_OFF_OWN_SET   = 8'h00;
  localparam logic [7:0] PLC_OFF_OWN_CLR   = 8'h04;
  localparam logic [7:0] PLC_OFF_OWN_STAT  = 8'h08;
  localparam logic [7:0] PLC_OFF_OE_SET    = 8'h10;
  localparam logic [7:0] PLC_OFF_OE_CLR    = 8'h14;
  localparam logic [7:0] PLC_OFF_OE_STAT   = 8'h18;
  localparam logic [7:0] PLC_OFF_GF_SET    = 8'h20;
  localparam logic [7:0] PLC_OFF_GF_CLR    = 8'h24;
  localparam logic [7:0] PLC_OFF_GF_STAT   = 8'h28;
  localparam logic [7:0] PLC_OFF_OD_SET    = 8'h30;
  localparam logic [7:0] PLC_OFF_OD_CLR    = 8'h34;
  localparam logic [7:0] PLC_OFF_OD_STAT   = 8'h38;
  localparam logic [7:0] PLC_OFF_PIN_STAT  = 8'h3c;
  localparam logic [7:0] PLC_OFF_IRQ_SET   = 8'h40;
  localparam logic [7:0] PLC_OFF_IRQ_CLR   = 8'h44;
  localparam logic [7:0] PLC_OFF_IRQ_MASK  = 8'h48;
  localparam logic [7:0] PLC_OFF_IRQ_STAT  = 8'h4c;
  localparam logic [7:0] PLC_OFF_MD_SET    = 8'h50;
  localparam logic [7:0] PLC_OFF_MD_CLR    = 8'h54;
  localparam logic [7:0] PLC_OFF_MD_STAT   = 8'h58;
  localparam logic [7:0] PLC_OFF_PU_DIS    = 8'h60;
  localparam logic [7:0] PLC_OFF_PU_EN     = 8'h64;
  localparam logic [7:0] PLC_OFF_PU_STAT   = 8'h68;
  localparam logic [7:0] PLC_OFF_SEL_A     = 8'h70;
  localparam logic [7:0] PLC_OFF_SEL_B     = 8'h74;
  localparam logic [7:0] PLC_OFF_SEL_STAT  = 8'h78;
  localparam logic [7:0] PLC_OFF_SW_SET    = 8'ha0;
  localparam logic [7:0] PLC_OFF_SW_CLR    = 8'ha4;
  localparam logic [7:0] PLC_OFF_SW_STAT   = 8'ha8;
  // ==========================================================================
  // Widths, reset values, timing
  localparam int          PLC_LINES        = 32;
  localparam logic [31:0] PLC_ZERO         = 32'h0000_0000;
  localparam logic [31:0] PLC_ONES         = 32'hffff_ffff;
  localparam logic [2:0]  PLC_SETTLE_CYC   = 3'h5;
endpackage : plc_pkg

/* shared/plc_in_if.sv */
// Interface between the line controller core and its input sampler
`timescale 1ns/1ps
interface plc_in_if #(parameter int W = 32);
  logic [W-1:0] pin_raw;
  logic [W-1:0] filt_en;
  logic         run;
  logic [W-1:0] level;
  modport filt (input pin_raw, input filt_en, input run, output level);
  modport ctrl (output pin_raw, output filt_en, output run, input level);
endinterface : plc_in_if

/* logic/plc_in_filter.sv */
// Pin input synchroniser and per-line glitch filter
`timescale 1ns/1ps
module plc_in_filter #(
  parameter int W = 32
) (
  input  wire logic ref_clk_in,
  plc_in_if.filt    io
);
  // ==========================================================================
  // Sampling chain
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] s4_r;
  logic [W-1:0] lvl_r;

  // Chain freezes with the controller clock so the last levels are kept
  always_ff @(posedge ref_clk_in) begin
    if (io.run) begin
      s1_r <= io.pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      s4_r <= s3_r;
    end
  end

  // ==========================================================================
  // Per-line acceptance: stage 2 and 3 agree; filtered lines also need stage 4
  for (genvar i = 0; i < W; i++) begin : g_line
    always_ff @(posedge ref_clk_in) begin
      if (io.run && (s2_r[i] == s3_r[i]) && (!io.filt_en[i] || (s3_r[i] == s4_r[i]))) begin
        lvl_r[i] <= s3_r[i];
      end
    end
  end

  assign io.level = lvl_r; // No fixed reset value: follows the pins
endmodule : plc_in_filter

/* logic/plc_top.sv */
// Parallel line controller: register file, pin drive and input change detection
//
// Summary of operation
// - every register 32 bits, bit n is line n
// - writes to missing lines have no effect
// - missing lines always read zero
// - lines without peripheral read owned by controller
// - ownership set write gives line to controller
// - ownership clear write hands line to peripheral
// - ownership status 0 peripheral, 1 controller
// - output enable set write enables driver
// - output enable clear write makes line input
// - data status writable only on masked-in bits
// - change status resets to zero
// - A select clears, B select sets status
// - stopped clock holds last sampled levels
// - pin level has no fixed reset value
// - ownership reset value set by integration
// - other status registers reset to zero
// - pull-up disable, enable, status consecutive words
// - sync write mask set, clear, status
// - reading change status clears all bits; a change in the reading cycle stays set
// - data set and clear writes update data status
// - masked change requests ORed onto one interrupt
// - direct data write updates lines at once
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module plc_top #(
  parameter logic [31:0] IMPL_MASK = 32'hffff_ffff, // Lines that exist
  parameter logic [31:0] MUX_MASK  = 32'hffff_ffff, // Lines with a peripheral
  parameter logic [31:0] OWN_RESET = 32'hffff_ffff  // Ownership after reset
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  input  wire logic        ctrl_clk_run_in,
  input  wire logic [31:0] pin_in,
  output logic      [31:0] pin_out,
  output logic      [31:0] pin_oe_out,
  output logic      [31:0] pullup_en_out,
  input  wire logic [31:0] periph_a_data_in,
  input  wire logic [31:0] periph_a_oe_in,
  input  wire logic [31:0] periph_b_data_in,
  input  wire logic [31:0] periph_b_oe_in,
  output logic             irq_out
);
  // ==========================================================================
  // Control registers
  logic [31:0] own_r;
  logic [31:0] oe_r;
  logic [31:0] gf_r;
  logic [31:0] odata_r;
  logic [31:0] imask_r;
  logic [31:0] istat_r;
  logic [31:0] md_r;
  logic [31:0] pu_r;
  logic [31:0] sel_r;
  logic [31:0] sw_r;
  logic [31:0] prev_lvl_r;
  logic [2:0]  settle_r;
  logic [31:0] rdata_r;
  logic [31:0] pin_out_r;
  logic [31:0] pin_oe_r;
  logic        irq_r;
  logic [31:0] wmask;
  logic [31:0] own_view;
  logic [31:0] change;
  logic [31:0] rd_mux;
  logic [31:0] istat_nxt;
  logic        istat_rd;
  logic [31:0] ctl_oe;
  logic [31:0] per_dat;
  logic [31:0] per_oe;

  // ==========================================================================
  // Input sampler
  plc_in_if #(.W(plc_pkg::PLC_LINES)) in_bus ();

  assign in_bus.pin_raw = pin_in;
  assign in_bus.filt_en = gf_r;
  assign in_bus.run     = ctrl_clk_run_in;

  plc_in_filter #(.W(plc_pkg::PLC_LINES)) u_filter (
    .ref_clk_in (ref_clk_in),
    .io         (in_bus.filt)
  );

  // ==========================================================================
  // Write decode helpers
  assign wmask    = reg_wdata_in & IMPL_MASK;
  assign own_view = (own_r | ~MUX_MASK) & IMPL_MASK;

  function automatic logic wr_at(input logic [7:0] off);
    wr_at = reg_wr_in && (reg_addr_in == off);
  endfunction : wr_at

  // Line ownership: set gives the controller, clear hands to peripheral
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      own_r <= OWN_RESET;
    end else if (wr_at(plc_pkg::PLC_OFF_OWN_SET)) begin
      own_r <= own_r | wmask;
    end else if (wr_at(plc_pkg::PLC_OFF_OWN_CLR)) begin
      own_r <= own_r & ~wmask;
    end
  end

  // Output enable, managed whoever owns the line
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      oe_r <= plc_pkg::PLC_ZERO;
    end else if (wr_at(plc_pkg::PLC_OFF_OE_SET)) begin
      oe_r <= oe_r | wmask;
    end else if (wr_at(plc_pkg::PLC_OFF_OE_CLR)) begin
      oe_r <= oe_r & ~wmask;
    end
  end

  // Glitch filter enables
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      gf_r <= plc_pkg::PLC_ZERO;
    end else if (wr_at(plc_pkg::PLC_OFF_GF_SET)) begin
      gf_r <= gf_r | wmask;
    end else if (wr_at(plc_pkg::PLC_OFF_GF_CLR)) begin
      gf_r <= gf_r & ~wmask;
    end
  end

  // Output data; reset to zero so the first driven level is defined
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      odata_r <= plc_pkg::PLC_ZERO;
    end else if (wr_at(plc_pkg::PLC_OFF_OD_SET)) begin
      odata_r <= odata_r | wmask;
    end else if (wr_at(plc_pkg::PLC_OFF_OD_CLR)) begin
      odata_r <= odata_r & ~wmask;
    end else if (wr_at(plc_pkg::PLC_OFF_OD_STAT)) begin
      // One write moves every unmasked line together, no transient
      odata_r <= (odata_r & ~(sw_r & IMPL_MASK)) | (wmask & sw_r);
    end
  end

  // Change interrupt mask
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      imask_r <= plc_pkg::PLC_ZERO;
    end else if (wr_at(plc_pkg::PLC_OFF_IRQ_SET)) begin
      imask_r <= imask_r | wmask;
    end else if (wr_at(plc_pkg::PLC_OFF_IRQ_CLR)) begin
      imask_r <= imask_r & ~wmask;
    end
  end

  // Open-drain select
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      md_r <= plc_pkg::PLC_ZERO;
    end else if (wr_at(plc_pkg::PLC_OFF_MD_SET)) begin
      md_r <= md_r | wmask;
    end else if (wr_at(plc_pkg::PLC_OFF_MD_CLR)) begin
      md_r <= md_r & ~wmask;
    end
  end

  // Pull-up: disable word first, then enable, then status
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pu_r <= plc_pkg::PLC_ZERO;
    end else if (wr_at(plc_pkg::PLC_OFF_PU_DIS)) begin
      pu_r <= pu_r & ~wmask;
    end else if (wr_at(plc_pkg::PLC_OFF_PU_EN)) begin
      pu_r <= pu_r | wmask;
    end
  end

  // Peripheral select: 0 is A, 1 is B
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sel_r <= plc_pkg::PLC_ZERO;
    end else if (wr_at(plc_pkg::PLC_OFF_SEL_A)) begin
      sel_r <= sel_r & ~wmask;
    end else if (wr_at(plc_pkg::PLC_OFF_SEL_B)) begin
      sel_r <= sel_r | wmask;
    end
  end

  // Synchronous write mask
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sw_r <= plc_pkg::PLC_ZERO;
    end else if (wr_at(plc_pkg::PLC_OFF_SW_SET)) begin
      sw_r <= sw_r | wmask;
    end else if (wr_at(plc_pkg::PLC_OFF_SW_CLR)) begin
      sw_r <= sw_r & ~wmask;
    end
  end

  // ==========================================================================
  // Input change detection
  // Levels carry no reset value, so detection waits until the chain is full
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      settle_r <= 3'h0;
    end else if (ctrl_clk_run_in && settle_r != plc_pkg::PLC_SETTLE_CYC) begin
      settle_r <= settle_r + 3'h1;
    end
  end

  // Previous sample only moves while the controller clock runs
  always_ff @(posedge ref_clk_in) begin
    if (ctrl_clk_run_in) begin
      prev_lvl_r <= in_bus.level;
    end
  end

  assign change = (settle_r == plc_pkg::PLC_SETTLE_CYC && ctrl_clk_run_in)
                  ? ((in_bus.level ^ prev_lvl_r) & IMPL_MASK) : plc_pkg::PLC_ZERO;
  assign istat_rd  = reg_rd_in && (reg_addr_in == plc_pkg::PLC_OFF_IRQ_STAT);
  // A change in the reading cycle survives the clear
  assign istat_nxt = (istat_rd ? plc_pkg::PLC_ZERO : istat_r) | change;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      istat_r <= plc_pkg::PLC_ZERO;
    end else begin
      istat_r <= istat_nxt;
    end
  end

  // Masked requests merged into one line, registered
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(istat_nxt & imask_r);
    end
  end

  // ==========================================================================
  // Pin drive
  // Open-drain lines only ever drive low; a high is left to the pull-up
  assign ctl_oe  = oe_r & ~(md_r & odata_r);
  assign per_dat = (sel_r & periph_b_data_in) | (~sel_r & periph_a_data_in);
  assign per_oe  = ((sel_r & periph_b_oe_in) | (~sel_r & periph_a_oe_in))
                   & ~(md_r & per_dat);

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pin_out_r <= plc_pkg::PLC_ZERO;
      pin_oe_r  <= plc_pkg::PLC_ZERO;
    end else begin
      pin_out_r <= ((own_view & odata_r) | (~own_view & per_dat)) & IMPL_MASK;
      pin_oe_r  <= ((own_view & ctl_oe) | (~own_view & per_oe)) & IMPL_MASK;
    end
  end

  // ==========================================================================
  // Read path
  always_comb begin
    case (reg_addr_in)
      plc_pkg::PLC_OFF_OWN_STAT: rd_mux = own_view;
      plc_pkg::PLC_OFF_OE_STAT:  rd_mux = oe_r;
      plc_pkg::PLC_OFF_GF_STAT:  rd_mux = gf_r;
      plc_pkg::PLC_OFF_OD_STAT:  rd_mux = odata_r;
      plc_pkg::PLC_OFF_PIN_STAT: rd_mux = in_bus.level;
      plc_pkg::PLC_OFF_IRQ_MASK: rd_mux = imask_r;
      plc_pkg::PLC_OFF_IRQ_STAT: rd_mux = istat_r;
      plc_pkg::PLC_OFF_MD_STAT:  rd_mux = md_r;
      plc_pkg::PLC_OFF_PU_STAT:  rd_mux = pu_r;
      plc_pkg::PLC_OFF_SEL_STAT: rd_mux = sel_r;
      plc_pkg::PLC_OFF_SW_STAT:  rd_mux = sw_r;
      default:                   rd_mux = plc_pkg::PLC_ZERO;
    endcase
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdata_r <= plc_pkg::PLC_ZERO;
    end else if (reg_rd_in) begin
      rdata_r <= rd_mux & IMPL_MASK;
    end else begin
      rdata_r <= plc_pkg::PLC_ZERO;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign pin_out       = pin_out_r;
  assign pin_oe_out    = pin_oe_r;
  assign pullup_en_out = pu_r;
  assign irq_out       = irq_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_rd_istat;
    reg_rd_in && reg_addr_in == plc_pkg::PLC_OFF_IRQ_STAT;
  endsequence

  sequence s_quiet;
    !reg_wr_in && !reg_rd_in;
  endsequence

  a_istat_rd_clear: assert property (s_rd_istat |=> ((istat_r & ~$past(change)) == 32'h0000_0000))
    else $error("change status not cleared by read");
  a_istat_set_wins: assert property (s_rd_istat ##0 (change != 32'h0000_0000)
    |=> ((istat_r & $past(change)) == $past(change)))
    else $error("change lost in reading cycle");
  a_irq_or_mask: assert property (##1 (irq_out == |($past(istat_nxt) & $past(imask_r))))
    else $error("interrupt output not masked OR of status");
  a_unmux_owned: assert property (((reg_rdata_out & ~MUX_MASK & IMPL_MASK) == (~MUX_MASK & IMPL_MASK))
    || !$past(reg_rd_in && reg_addr_in == plc_pkg::PLC_OFF_OWN_STAT))
    else $error("unmuxed line not owned");
  a_unimpl_zero: assert property ((reg_rdata_out & ~IMPL_MASK) == 32'h0000_0000)
    else $error("missing line reads nonzero");
  a_wo_read_zero: assert property (reg_rd_in && (reg_addr_in == plc_pkg::PLC_OFF_OWN_SET
    || reg_addr_in == plc_pkg::PLC_OFF_SW_CLR || reg_addr_in == 8'h0c)
    |=> reg_rdata_out == 32'h0000_0000)
    else $error("write-only or reserved word reads nonzero");
  a_odsr_masked: assert property (reg_wr_in && reg_addr_in == plc_pkg::PLC_OFF_OD_STAT
    |=> ((odata_r ^ $past(odata_r)) & ~$past(sw_r)) == 32'h0000_0000)
    else $error("masked-off data bit changed");
  // Kept as two checks: a trailing implication would let a missed set pass vacuously
  a_sel_b_set: assert property (reg_wr_in && reg_addr_in == plc_pkg::PLC_OFF_SEL_B
    |=> ((sel_r & $past(wmask)) == $past(wmask)))
    else $error("B select did not set status");
  a_sel_hold: assert property (s_quiet |=> $stable(sel_r))
    else $error("select status moved without a write");
  a_oe_set: assert property (reg_wr_in && reg_addr_in == plc_pkg::PLC_OFF_OE_SET
    |=> ((oe_r & $past(wmask)) == $past(wmask))
    && ((oe_r & ~$past(wmask)) == ($past(oe_r) & ~$past(wmask))))
    else $error("output enable set wrong");
endmodule : plc_top

/* tb/plc_pin_model.sv */
// Pad-side model: pad levels from controller, outside drivers and pull-ups
`timescale 1ns/1ps
module plc_pin_model (
  input  wire logic        ref_clk_in,
  input  wire logic [31:0] pin_out_in,
  input  wire logic [31:0] pin_oe_in,
  input  wire logic [31:0] pullup_in,
  input  wire logic [31:0] ext_en_in,
  input  wire logic [31:0] ext_val_in,
  output logic      [31:0] level_out
);
  logic [31:0] drv;
  logic [31:0] last_r = 32'h0000_0000;
  // ==========================================================================
  // Pad level
  // Controller drive wins over an outside driver; a line left floating
  // shows the inverse of its last level, so a stale value never looks valid
  assign drv = pin_oe_in | ext_en_in | pullup_in;
  assign level_out = (pin_oe_in & pin_out_in)
                   | (~pin_oe_in & ext_en_in & ext_val_in)
                   | (~pin_oe_in & ~ext_en_in & (pullup_in | ~last_r));
  // Remember the last level seen while the line was held
  always @(posedge ref_clk_in) begin
    last_r <= (drv & level_out) | (~drv & last_r);
  end
endmodule : plc_pin_model

/* tb/plc_tb_top.sv */
// Self-checking testbench of the parallel line controller
`timescale 1ns/1ps
`define PLC_CHK(nm, e, g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) begin \
      num_errors++; \
      $display("MISMATCH %s exp %h got %h", nm, e, g); \
    end \
  end
module parallel_io_line_controller_tb_top;
  localparam logic [31:0] IMPL = 32'h0fff_ffff;
  localparam logic [31:0] MUXL = 32'h00ff_ffff;
  localparam logic [31:0] OWNR = 32'h0000_ffff;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [7:0]  addr    = 8'h00;
  logic [31:0] wdata   = 32'h0000_0000;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        run     = 1'b1;
  logic [31:0] ext_en  = 32'h4000_0f00;
  logic [31:0] ext_val = 32'h0000_0000;
  logic [31:0] rdata;
  logic [31:0] pin_lvl;
  logic [31:0] pin_o;
  logic [31:0] pin_oe;
  logic [31:0] pu;
  logic        irq;
  logic [31:0] d;
  int          num_errors  = 0;
  int          comparisons = 0;
  logic [7:0] sa [8] = '{8'h00, 8'h10, 8'h20, 8'h40, 8'h50, 8'h64, 8'h74, 8'ha0};
  logic [7:0] ca [8] = '{8'h04, 8'h14, 8'h24, 8'h44, 8'h54, 8'h60, 8'h70, 8'ha4};
  logic [7:0] ta [8] = '{8'h08, 8'h18, 8'h28, 8'h48, 8'h58, 8'h68, 8'h78, 8'ha8};
  logic [7:0] za [18] = '{8'h18, 8'h28, 8'h48, 8'h58, 8'h68, 8'h78, 8'ha8, 8'h38,
                          8'h00, 8'h04, 8'h10, 8'h30, 8'h40, 8'h74, 8'ha0, 8'h0c,
                          8'h80, 8'hac};
  // ==========================================================================
  // Design, pad model and clock
  plc_top #(.IMPL_MASK(IMPL), .MUX_MASK(MUXL), .OWN_RESET(OWNR)) dut_u (
    .ref_clk_in(ref_clk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .ctrl_clk_run_in(run),
    .pin_in(pin_lvl), .pin_out(pin_o), .pin_oe_out(pin_oe), .pullup_en_out(pu),
    .periph_a_data_in(32'h0000_0001), .periph_a_oe_in(32'h0000_0003),
    .periph_b_data_in(32'h0000_0002), .periph_b_oe_in(32'h0000_0002),
    .irq_out(irq));
  plc_pin_model pad_u (.ref_clk_in(ref_clk), .pin_out_in(pin_o), .pin_oe_in(pin_oe),
    .pullup_in(pu), .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pin_lvl));
  always #5 ref_clk = ~ref_clk;
  // ==========================================================================
  // Bus tasks: one-cycle strobes launched right after a rising edge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd_reg(a, v);
    `PLC_CHK($sformatf("reg_%h", a), e, v)
  endtask : chk_reg
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_cyc
  task automatic test_done;
    if (num_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  // ==========================================================================
  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    test_done();
  end
  // ==========================================================================
  // Test sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    // Reset values, write-only and reserved places
    chk_reg(8'h08, (OWNR | ~MUXL) & IMPL);
    foreach (za[i]) chk_reg(za[i], 32'h0000_0000);
    // Set, clear and status triplets; read-only status ignores writes
    for (int i = 0; i < 8; i++) begin
      wr_reg(sa[i], 32'hffff_ffff);
      wr_reg(ta[i], 32'h0000_0000);
      chk_reg(ta[i], IMPL);
      wr_reg(ca[i], 32'h0000_00f0);
      chk_reg(ta[i], (IMPL & ~32'h0000_00f0) | (i == 0 ? ~MUXL & IMPL : 32'h0));
      wr_reg(ca[i], 32'hffff_ffff);
      chk_reg(ta[i], i == 0 ? ~MUXL & IMPL : 32'h0);
    end
    // Output data by set/clear, then by masked direct write
    wr_reg(8'h00, 32'hffff_ffff);
    wr_reg(8'h10, 32'h0000_00ff);
    wr_reg(8'h30, 32'h0000_000f);
    wr_reg(8'h34, 32'h0000_0003);
    chk_reg(8'h38, 32'h0000_000c);
    wr_reg(8'h38, 32'hffff_ffff);
    chk_reg(8'h38, 32'h0000_000c);
    wr_reg(8'ha0, 32'h0000_00f0);
    wr_reg(8'h38, 32'h0000_00a5);
    chk_reg(8'h38, 32'h0000_00ac);
    wait_cyc(6);
    `PLC_CHK("pin_out", 8'hac, pin_o[7:0])
    `PLC_CHK("pin_oe", 8'hff, pin_oe[7:0])
    rd_reg(8'h3c, d);
    `PLC_CHK("level", 8'hac, d[7:0])
    `PLC_CHK("level_hi", 4'h0, d[31:28])
    // Peripheral ownership and A/B choice of drive
    wr_reg(8'h04, 32'h0000_0003);
    wr_reg(8'h70, 32'h0000_0003);
    wait_cyc(3);
    `PLC_CHK("oe_a", 2'h3, pin_oe[1:0])
    `PLC_CHK("out_a", 2'h1, pin_o[1:0])
    wr_reg(8'h74, 32'h0000_0003);
    wait_cyc(3);
    `PLC_CHK("oe_b", 2'h2, pin_oe[1:0])
    `PLC_CHK("out_b", 1'h1, pin_o[1])
    wr_reg(8'h00, 32'h0000_0003);
    wait_cyc(3);
    `PLC_CHK("oe_own", 2'h3, pin_oe[1:0])
    `PLC_CHK("out_own", 2'h0, pin_o[1:0])
    // Input change: clear stale events, then mask in line 8 only
    wr_reg(8'h14, 32'hffff_ffff);
    wait_cyc(10);
    rd_reg(8'h4c, d);
    wr_reg(8'h40, 32'h0000_0100);
    @(posedge ref_clk);
    ext_val <= 32'h4000_0300;
    wait_cyc(8);
    `PLC_CHK("irq_on", 1'h1, irq)
    chk_reg(8'h4c, 32'h0000_0300);
    chk_reg(8'h4c, 32'h0000_0000);
    wait_cyc(2);
    `PLC_CHK("irq_off", 1'h0, irq)
    @(posedge ref_clk);
    ext_val <= 32'h4000_0100;
    wait_cyc(8);
    `PLC_CHK("irq_masked", 1'h0, irq)
    chk_reg(8'h4c, 32'h0000_0200);
    // Stopped controller clock keeps the levels sampled before the stop
    @(posedge ref_clk);
    run <= 1'b0;
    @(posedge ref_clk);
    ext_val <= 32'h4000_0500;
    wait_cyc(8);
    rd_reg(8'h3c, d);
    `PLC_CHK("level_frozen", 4'h1, d[11:8])
    @(posedge ref_clk);
    run <= 1'b1;
    wait_cyc(8);
    rd_reg(8'h3c, d);
    `PLC_CHK("level_live", 4'h5, d[11:8])
    // A filtered change landing in the very cycle of a status read survives the clear
    rd_reg(8'h4c, d);
    wr_reg(8'h20, 32'h0000_0100);
    @(posedge ref_clk);
    ext_val <= 32'h4000_0400;
    repeat (4) @(posedge ref_clk);
    rd_reg(8'h4c, d);
    `PLC_CHK("istat_race", 32'h0000_0000, d)
    chk_reg(8'h4c, 32'h0000_0100);
    // Open-drain line with data high releases the pad; its neighbour drives
    wr_reg(8'h10, 32'h0000_000c);
    wr_reg(8'h50, 32'h0000_0004);
    wait_cyc(2);
    `PLC_CHK("oe_open_drain", 2'h2, pin_oe[3:2])
    `PLC_CHK("out_open_drain", 2'h3, pin_o[3:2])
    // Pull-up enables reach the pads
    wr_reg(8'h64, 32'h0000_f000);
    wait_cyc(1);
    `PLC_CHK("pullup_pads", 32'h0000_f000, pu)
    test_done();
  end
endmodule : parallel_io_line_controller_tb_top
